/* shared/ast_pkg.sv */
// Package of constants and types for the asynchronous serial transmitter
// Operation
// R01 - Frame is start bit, eight or nine data bits, one stop bit, NRZ
// R02 - Data bits leave least significant bit first
// R03 - A dedicated 8-bit rate generator derives the bit timing
// R04 - Generator output is x16 bit rate with high_rate_select, else x64
// R05 - Transmitter runs independently, sharing format and rate with receiver
// R06 - No hardware parity; software may carry parity in ninth bit
// R07 - Asynchronous operation halts during sleep
// R08 - Asynchronous mode whenever clocked_mode_select is zero
// R09 - Shift register reloads only after stop bit, then takes pending buffer word
// R10 - Buffer empties on handoff; empty flag sets one instruction cycle later
// R11 - Empty flag set regardless of irq enable; only a buffer write clears it
// R12 - Transmit interrupt request only while flag and tx_irq_enable both set
// R13 - shift_empty_status sets/clears one instruction cycle after empty/load
// R14 - shift_empty_status drives no interrupt logic
// R15 - Shift register is not visible to software
// R16 - Setting tx_enable sets the buffer empty flag
// R17 - Frame starts after enable, buffer data and a shift clock, either order; code sends the start bit at load without waiting for a tick
// R18 - Buffer write with empty shift register transfers immediately
// R19 - Clearing tx_enable aborts frame, resets transmitter, releases the pin
// R20 - nine_bit_tx_select sends ninth_tx_bit as ninth data bit
// R21 - Software sets rate, mode, port, enables, then data, then interrupts
// R22 - Bit rate is osc/(64(X+1)) low speed, osc/(16(X+1)) high speed
// R23 - Writing rate_divisor resets the rate generator timer
// R24 - Enabled idle transmitter holds the line high
package ast_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
   localparam logic [7:0] ADDR_TX_BUFFER = 8'h04;
   localparam logic [7:0] ADDR_RATE_DIV = 8'h08;
   localparam logic [7:0] ADDR_FLAGS = 8'h0C;
   localparam logic [7:0] ADDR_ENABLES = 8'h10;
   localparam logic [7:0] ADDR_PORT = 8'h14;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int BIT_NINTH = 0;
   localparam int BIT_SHIFT_EMPTY = 1;
   localparam int BIT_HIGH_RATE = 2;
   localparam int BIT_CLOCKED_MODE = 4;
   localparam int BIT_TX_ENABLE = 5;
   localparam int BIT_NINE_SEL = 6;
   localparam int BIT_CLK_SOURCE = 7;
   localparam int BIT_TX_FLAG = 4;
   localparam int BIT_TX_IRQ_EN = 4;
   localparam int BIT_PORT_EN = 7;
   localparam int BIT_GLOBAL_IRQ = 1;
   localparam int BIT_PERIPH_IRQ = 0;
   // ****************************************
   // Reset values and timing
   // ****************************************
   localparam logic [7:0] CTRL_RESET = 8'h02;
   localparam logic [7:0] RATE_RESET = 8'h00;
   localparam logic [5:0] OVS_HIGH_LAST = 6'h0F;
   localparam logic [5:0] OVS_LOW_LAST = 6'h3F;
   localparam logic [3:0] BITS_EIGHT = 4'h9;
   localparam logic [3:0] BITS_NINE = 4'hA;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int INSTR_CYCLE_CLKS = 4;

   typedef enum {TX_IDLE, TX_SHIFT} ast_tx_state_t;

   typedef struct packed
   {
      logic nine_sel;
      logic ninth_bit;
      logic high_rate;
      logic tx_enable;
      logic clocked_mode;
      logic port_enable;
   } ast_cfg_t;
endpackage

/* verif/ast_rx_model.sv */
// Remote receiver model on the serial line
`timescale 1ns/1ps
module ast_rx_model
(
   input wire logic clk_sys,
   input wire logic line,
   input wire logic nine,
   input wire logic [15:0] bit_clks,
   output logic [8:0] rx_word,
   output logic rx_stop,
   output int rx_count
);
   int i;
   // ****************************************
   // Receiver
   // ****************************************
   // No parity is checked; the ninth bit is kept raw
   initial
   begin
      rx_word = 9'h000;
      rx_stop = 1'b1;
      rx_count = 0;
      forever
      begin
         @(posedge clk_sys);
         if (line === 1'b0)
         begin
            // Sample every bit at its centre
            repeat (bit_clks / 2 - 1) @(posedge clk_sys);
            for (i = 0; i < (nine ? 9 : 8); i++)
            begin
               repeat (bit_clks) @(posedge clk_sys);
               rx_word[i] = line;
            end
            if (!nine) rx_word[8] = 1'b0;
            repeat (bit_clks) @(posedge clk_sys);
            rx_stop = line;
            rx_count++;
         end
      end
   end
endmodule

/* verif/ast_transmitter_checker.sv */
// Bus, line and interrupt checker of the transmitter
`timescale 1ns/1ps
module ast_transmitter_checker
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sleep,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic serial_out_pin_o,
   input wire logic serial_out_pin_oe,
   input wire logic tx_irq,
   input wire logic cpu_irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ****************************************
   // Assertions
   // ****************************************
   // Bits last at least 9 clocks
   chk_bit_hold: assert property (
      $changed(serial_out_pin_o) && serial_out_pin_oe
      |=> ($stable(serial_out_pin_o) || !serial_out_pin_oe) [*8])
      else $error("bit too short");
   chk_idle_high: assert property (
      !serial_out_pin_oe |-> serial_out_pin_o)
      else $error("released line low");
   chk_sleep_hold: assert property (
      sleep && $past(sleep) && $past(sleep, 2) && serial_out_pin_oe
      && $past(serial_out_pin_oe) |-> $stable(serial_out_pin_o))
      else $error("line moved during sleep");
   chk_irq_chain: assert property (
      cpu_irq |-> tx_irq || $past(tx_irq))
      else $error("cpu irq without tx irq");
   chk_b_latency: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_r_latency: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   chk_rdata_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper rdata set");
   chk_unmapped_err: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
      |=> s_axi_rresp == ast_pkg::RESP_SLVERR)
      else $error("unmapped read not refused");
   chk_aw_busy: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready while busy");
endmodule

bind ast_transmitter ast_transmitter_checker i_ast_transmitter_checker (.*);

/* verif/ast_transmitter_tb.sv */
// Testbench of the serial transmitter
`timescale 1ns/1ps
module ast_transmitter_tb;
   // ****************************************
   // Signals
   // ****************************************
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic sleep = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic serial_out_pin_o;
   logic serial_out_pin_oe;
   logic tx_irq;
   logic cpu_irq;
   logic line;
   logic nine = 1'b0;
   logic [15:0] bit_clks = 16'h0010;
   logic [8:0] rx_word;
   logic rx_stop;
   int rx_count;
   int fails = 0;
   int total_checks = 0;
   int base;
   logic [31:0] rd;
   logic [1:0] rsp;

   // Pull-up holds the released line high
   assign line = serial_out_pin_oe ? serial_out_pin_o : 1'b1;
   always #50 clk_sys = ~clk_sys;

   ast_transmitter i_ast_transmitter (.*);
   ast_rx_model i_ast_rx_model (.*);
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic timed_out();
      check(32'h0, 32'h1);
      finish_test();
   endtask

   // Handshakes are seen just before their edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic ha, hw, hb;
      n = 0;
      hb = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!hb)
      begin
         @(negedge clk_sys);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk_sys);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) s_axi_bready <= 1'b0;
         n++;
         if (n > 100) timed_out();
      end
   endtask

   task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ha, hr;
      n = 0;
      hr = 1'b0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!hr)
      begin
         @(negedge clk_sys);
         ha = s_axi_arvalid && s_axi_arready;
         hr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk_sys);
         if (ha) s_axi_arvalid <= 1'b0;
         if (hr) s_axi_rready <= 1'b0;
         n++;
         if (n > 100) timed_out();
      end
   endtask

   // Two instruction cycles settle after a write
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, rsp);
      check(32'(rsp), 32'(ast_pkg::RESP_OKAY));
      repeat (8) @(negedge clk_sys);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rdr(a, rd, rsp);
      check(rd, e);
   endtask

   task automatic wait_rx(input int n);
      int k;
      for (k = 0; k < 40000 && rx_count < n; k++)
         @(posedge clk_sys);
      if (rx_count < n) timed_out();
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rchk(ast_pkg::ADDR_CTRL_STATUS, 32'h02);
      rchk(ast_pkg::ADDR_RATE_DIV, 32'h0);
      rchk(ast_pkg::ADDR_FLAGS, 32'h0);
      w(ast_pkg::ADDR_RATE_DIV, 32'h0);
      w(ast_pkg::ADDR_CTRL_STATUS, 32'h04);
      w(ast_pkg::ADDR_PORT, 32'h80);
      w(ast_pkg::ADDR_ENABLES, 32'h10);
      check({31'h0, tx_irq}, 32'h0);
      check({31'h0, serial_out_pin_oe}, 32'h0);
      w(ast_pkg::ADDR_CTRL_STATUS, 32'h24);
      rchk(ast_pkg::ADDR_FLAGS, 32'h10);
      check({31'h0, tx_irq}, 32'h1);
      check({31'h0, cpu_irq}, 32'h0);
      w(ast_pkg::ADDR_PORT, 32'h83);
      check({31'h0, cpu_irq}, 32'h1);
      rchk(ast_pkg::ADDR_CTRL_STATUS, 32'h26);
      w(ast_pkg::ADDR_FLAGS, 32'h0);
      rchk(ast_pkg::ADDR_FLAGS, 32'h10);
      // Back-to-back words
      w(ast_pkg::ADDR_TX_BUFFER, 32'hA5);
      w(ast_pkg::ADDR_TX_BUFFER, 32'h3C);
      rchk(ast_pkg::ADDR_FLAGS, 32'h0);
      check({31'h0, tx_irq}, 32'h0);
      rchk(ast_pkg::ADDR_CTRL_STATUS, 32'h24);
      wait_rx(1);
      check({23'h0, rx_word}, 32'hA5);
      check({31'h0, rx_stop}, 32'h1);
      wait_rx(2);
      check({23'h0, rx_word}, 32'h3C);
      repeat (32) @(negedge clk_sys);
      rchk(ast_pkg::ADDR_CTRL_STATUS, 32'h26);
      rchk(ast_pkg::ADDR_FLAGS, 32'h10);
      // Nine-bit frames
      nine <= 1'b1;
      w(ast_pkg::ADDR_CTRL_STATUS, 32'h65);
      w(ast_pkg::ADDR_TX_BUFFER, 32'h5A);
      wait_rx(3);
      check({23'h0, rx_word}, 32'h15A);
      w(ast_pkg::ADDR_CTRL_STATUS, 32'h64);
      w(ast_pkg::ADDR_TX_BUFFER, 32'h81);
      wait_rx(4);
      check({23'h0, rx_word}, 32'h81);
      repeat (32) @(negedge clk_sys);
      // Low speed, 128 clocks a bit
      nine <= 1'b0;
      bit_clks <= 16'h0080;
      w(ast_pkg::ADDR_RATE_DIV, 32'h01);
      w(ast_pkg::ADDR_CTRL_STATUS, 32'h20);
      w(ast_pkg::ADDR_TX_BUFFER, 32'hC3);
      wait_rx(5);
      check({23'h0, rx_word}, 32'hC3);
      repeat (100) @(negedge clk_sys);
      // Abort in mid-frame
      bit_clks <= 16'h0010;
      w(ast_pkg::ADDR_RATE_DIV, 32'h0);
      w(ast_pkg::ADDR_CTRL_STATUS, 32'h24);
      w(ast_pkg::ADDR_TX_BUFFER, 32'hFF);
      repeat (40) @(negedge clk_sys);
      w(ast_pkg::ADDR_CTRL_STATUS, 32'h04);
      check({31'h0, serial_out_pin_oe}, 32'h0);
      repeat (200) @(negedge clk_sys);
      rchk(ast_pkg::ADDR_CTRL_STATUS, 32'h06);
      w(ast_pkg::ADDR_CTRL_STATUS, 32'h34);
      check({31'h0, serial_out_pin_oe}, 32'h0);
      w(ast_pkg::ADDR_CTRL_STATUS, 32'h24);
      rchk(ast_pkg::ADDR_FLAGS, 32'h10);
      check({30'h0, serial_out_pin_oe, serial_out_pin_o}, 32'h3);
      // Sleep holds a word back
      base = rx_count;
      @(posedge clk_sys);
      sleep <= 1'b1;
      w(ast_pkg::ADDR_TX_BUFFER, 32'h96);
      repeat (400) @(negedge clk_sys);
      check(32'(rx_count), 32'(base));
      @(posedge clk_sys);
      sleep <= 1'b0;
      wait_rx(base + 1);
      check({23'h0, rx_word}, 32'h96);
      rdr(8'h18, rd, rsp);
      check({30'h0, rsp}, {30'h0, ast_pkg::RESP_SLVERR});
      wr(8'h18, 32'h55, rsp);
      check({30'h0, rsp}, {30'h0, ast_pkg::RESP_SLVERR});
      finish_test();
   end
endmodule

/* verilog/ast_rate_gen.sv */
// Rate generator: 8-bit reloading timer giving the oversample tick
`timescale 1ns/1ps
module ast_rate_gen
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] rate_divisor,
   input wire logic restart,
   input wire logic run,
   output logic tick
);
   logic [7:0] count_r;
   logic [7:0] count_nxt;
   logic tick_nxt;

   // ****************************************
   // Down counter, tick every divisor+1 clocks
   // ****************************************
   always_comb
   begin
      count_nxt = count_r;
      tick_nxt = 1'b0;
      if (restart || !run)
      begin
         count_nxt = rate_divisor; // [R23]
      end
      else if (count_r == 8'h00)
      begin
         count_nxt = rate_divisor; // [R03]
         tick_nxt = 1'b1;
      end
      else
      begin
         count_nxt = count_r - 8'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_r <= 8'h00;
         tick <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         tick <= tick_nxt;
      end
   end
endmodule

/* verilog/ast_transmitter.sv */
// Asynchronous serial transmitter with AXI4-Lite register access
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module ast_transmitter
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sleep,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic serial_out_pin_o,
   output logic serial_out_pin_oe,
   output logic tx_irq,
   output logic cpu_irq
);
   // ****************************************
   // State
   // ****************************************
   ast_pkg::ast_cfg_t cfg_r, cfg_nxt;
   logic [7:0] rate_r, rate_nxt;
   logic [7:0] buf_r, buf_nxt;
   logic buf_ninth_r, buf_ninth_nxt;
   logic buf_full_r, buf_full_nxt;
   logic [9:0] shift_r, shift_nxt;
   logic [3:0] bits_left_r, bits_left_nxt;
   logic [5:0] ovs_r, ovs_nxt;
   ast_pkg::ast_tx_state_t state_r, state_nxt;
   logic [ast_pkg::INSTR_CYCLE_CLKS-1:0] flag_dly_r, flag_dly_nxt;
   logic [ast_pkg::INSTR_CYCLE_CLKS-1:0] empty_dly_r, empty_dly_nxt;
   logic tx_flag_r, tx_flag_nxt;
   logic shift_empty_r, shift_empty_nxt;
   logic tx_irq_en_r, tx_irq_en_nxt;
   logic gie_r, gie_nxt, peripheral_irq_enable_r, peripheral_irq_enable_nxt;
   logic line_nxt, oe_nxt, tx_irq_nxt, cpu_irq_nxt;
   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [7:0] aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic bvalid_nxt, awready_nxt, wready_nxt, arready_nxt, rvalid_nxt;
   logic [1:0] bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt;
   logic tick;
   logic rate_write;
   logic active;

   // ****************************************
   // Rate generator
   // ****************************************
   ast_rate_gen u_rate
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .rate_divisor(rate_r), // [R05]
      .restart(rate_write),
      .run(active),
      .tick(tick)
   );

   function automatic logic [7:0] ctrl_image(input ast_pkg::ast_cfg_t c, input logic se);
      logic [7:0] v;
      v = 8'h00;
      v[ast_pkg::BIT_NINTH] = c.ninth_bit;
      v[ast_pkg::BIT_SHIFT_EMPTY] = se;
      v[ast_pkg::BIT_HIGH_RATE] = c.high_rate;
      v[ast_pkg::BIT_CLOCKED_MODE] = c.clocked_mode;
      v[ast_pkg::BIT_TX_ENABLE] = c.tx_enable;
      v[ast_pkg::BIT_NINE_SEL] = c.nine_sel;
      return v;
   endfunction

   // Sleep stops the rate generator and the load, not bus writes or status; clocked mode is not served here
   assign active = cfg_r.port_enable && cfg_r.tx_enable && !cfg_r.clocked_mode
      && !sleep; // [R07] [R08]

   // ****************************************
   // Bus, registers and transmitter
   // ****************************************
   always_comb
   begin
      logic do_write;
      logic buf_write;
      logic load;
      logic [7:0] wb;
      logic [3:0] first;
      do_write = 1'b0;
      buf_write = 1'b0;
      load = 1'b0;
      wb = 8'h00;
      first = cfg_r.nine_sel ? ast_pkg::BITS_NINE : ast_pkg::BITS_EIGHT;
      cfg_nxt = cfg_r;
      rate_nxt = rate_r;
      rate_write = 1'b0;
      buf_nxt = buf_r;
      buf_ninth_nxt = buf_ninth_r;
      buf_full_nxt = buf_full_r;
      shift_nxt = shift_r;
      bits_left_nxt = bits_left_r;
      ovs_nxt = ovs_r;
      state_nxt = state_r;
      tx_flag_nxt = tx_flag_r;
      tx_irq_en_nxt = tx_irq_en_r;
      gie_nxt = gie_r;
      peripheral_irq_enable_nxt = peripheral_irq_enable_r;
      aw_full_nxt = aw_full_r;
      w_full_nxt = w_full_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = s_axi_bvalid;
      bresp_nxt = s_axi_bresp;
      rvalid_nxt = s_axi_rvalid;
      rresp_nxt = s_axi_rresp;
      rdata_nxt = s_axi_rdata;
      // Address and data accepted in either order, one write at a time
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_full_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_full_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         bvalid_nxt = 1'b0;
      end
      if (aw_full_r && w_full_r && !s_axi_bvalid)
      begin
         do_write = w_strb_r[0];
         wb = w_data_r[7:0];
         aw_full_nxt = 1'b0;
         w_full_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = ast_pkg::RESP_OKAY;
         unique case (aw_addr_r)
            ast_pkg::ADDR_CTRL_STATUS, ast_pkg::ADDR_TX_BUFFER, ast_pkg::ADDR_RATE_DIV,
            ast_pkg::ADDR_FLAGS, ast_pkg::ADDR_ENABLES, ast_pkg::ADDR_PORT:
               bresp_nxt = ast_pkg::RESP_OKAY;
            default:
            begin
               bresp_nxt = ast_pkg::RESP_SLVERR;
               do_write = 1'b0;
            end
         endcase
      end
      if (do_write)
      begin
         unique case (aw_addr_r)
            ast_pkg::ADDR_CTRL_STATUS:
            begin
               cfg_nxt.ninth_bit = wb[ast_pkg::BIT_NINTH];
               cfg_nxt.high_rate = wb[ast_pkg::BIT_HIGH_RATE];
               cfg_nxt.clocked_mode = wb[ast_pkg::BIT_CLOCKED_MODE];
               cfg_nxt.tx_enable = wb[ast_pkg::BIT_TX_ENABLE];
               cfg_nxt.nine_sel = wb[ast_pkg::BIT_NINE_SEL];
            end
            ast_pkg::ADDR_TX_BUFFER:
            begin
               buf_write = 1'b1;
               buf_nxt = wb;
               buf_ninth_nxt = cfg_r.ninth_bit; // [R20]
               buf_full_nxt = 1'b1;
               tx_flag_nxt = 1'b0; // [R11]
            end
            ast_pkg::ADDR_RATE_DIV:
            begin
               rate_nxt = wb;
               rate_write = 1'b1; // [R23]
            end
            ast_pkg::ADDR_ENABLES:
               tx_irq_en_nxt = wb[ast_pkg::BIT_TX_IRQ_EN];
            ast_pkg::ADDR_PORT:
            begin
               cfg_nxt.port_enable = wb[ast_pkg::BIT_PORT_EN];
               gie_nxt = wb[ast_pkg::BIT_GLOBAL_IRQ];
               peripheral_irq_enable_nxt = wb[ast_pkg::BIT_PERIPH_IRQ];
            end
            default:
               do_write = 1'b0;
         endcase
      end
      if (cfg_nxt.tx_enable && !cfg_r.tx_enable)
      begin
         tx_flag_nxt = 1'b1; // [R16]
      end
      // Reads; the shift register has no address [R15]
      if (s_axi_rvalid && s_axi_rready)
      begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = ast_pkg::RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         unique case (s_axi_araddr)
            ast_pkg::ADDR_CTRL_STATUS:
               rdata_nxt[7:0] = ctrl_image(cfg_r, shift_empty_r);
            ast_pkg::ADDR_TX_BUFFER:
               rdata_nxt[7:0] = buf_r;
            ast_pkg::ADDR_RATE_DIV:
               rdata_nxt[7:0] = rate_r;
            ast_pkg::ADDR_FLAGS:
               rdata_nxt[ast_pkg::BIT_TX_FLAG] = tx_flag_r;
            ast_pkg::ADDR_ENABLES:
               rdata_nxt[ast_pkg::BIT_TX_IRQ_EN] = tx_irq_en_r;
            ast_pkg::ADDR_PORT:
            begin
               rdata_nxt[ast_pkg::BIT_PORT_EN] = cfg_r.port_enable;
               rdata_nxt[ast_pkg::BIT_GLOBAL_IRQ] = gie_r;
               rdata_nxt[ast_pkg::BIT_PERIPH_IRQ] = peripheral_irq_enable_r;
            end
            default:
               rresp_nxt = ast_pkg::RESP_SLVERR;
         endcase
      end
      // Transmitter
      unique case (state_r)
         ast_pkg::TX_IDLE:
         begin
            // Load waits for the previous stop bit, then is immediate [R09] [R18]
            if (active && buf_full_r && !buf_write)
            begin
               load = 1'b1;
               shift_nxt = {1'b1, buf_ninth_r, buf_r}; // [R01]
               if (!cfg_r.nine_sel)
               begin
                  shift_nxt[8] = 1'b1; // [R06]
               end
               bits_left_nxt = first;
               ovs_nxt = 6'h00;
               buf_full_nxt = 1'b0;
               state_nxt = ast_pkg::TX_SHIFT;
            end
         end
         ast_pkg::TX_SHIFT:
         begin
            // Start bit goes out first; first oversample tick begins timing [R17]
            if (tick)
            begin
               if (ovs_r == (cfg_r.high_rate ? ast_pkg::OVS_HIGH_LAST
                  : ast_pkg::OVS_LOW_LAST)) // [R04] [R22]
               begin
                  ovs_nxt = 6'h00;
                  if (bits_left_r == 4'h0)
                  begin
                     state_nxt = ast_pkg::TX_IDLE;
                  end
                  else
                  begin
                     if (bits_left_r != first)
                     begin
                        shift_nxt = {1'b1, shift_r[9:1]}; // [R02]
                     end
                     bits_left_nxt = bits_left_r - 4'h1;
                  end
               end
               else
               begin
                  ovs_nxt = ovs_r + 6'h01;
               end
            end
         end
      endcase
      if (!cfg_r.tx_enable)
      begin
         state_nxt = ast_pkg::TX_IDLE; // [R19]
         ovs_nxt = 6'h00;
      end
      // Status bits follow the handoff one instruction cycle late [R10] [R13]
      flag_dly_nxt = {flag_dly_r[ast_pkg::INSTR_CYCLE_CLKS-2:0], load};
      empty_dly_nxt = {empty_dly_r[ast_pkg::INSTR_CYCLE_CLKS-2:0],
         state_nxt == ast_pkg::TX_IDLE};
      if (flag_dly_r[ast_pkg::INSTR_CYCLE_CLKS-1])
      begin
         tx_flag_nxt = 1'b1; // [R10] [R11]
      end
      shift_empty_nxt = empty_dly_r[ast_pkg::INSTR_CYCLE_CLKS-1]; // [R13] [R14]
      // Line drive; released when disabled
      oe_nxt = cfg_r.tx_enable && cfg_r.port_enable && !cfg_r.clocked_mode; // [R19]
      line_nxt = 1'b1; // [R24] [R19]
      if (state_r == ast_pkg::TX_IDLE && load)
      begin
         line_nxt = 1'b0; // [R01]
      end
      else if (oe_nxt && state_r == ast_pkg::TX_SHIFT && state_nxt == ast_pkg::TX_SHIFT)
      begin
         line_nxt = (bits_left_nxt == first) ? 1'b0 : shift_nxt[0];
      end
      tx_irq_nxt = tx_flag_r && tx_irq_en_r; // [R12]
      cpu_irq_nxt = tx_irq_nxt && gie_r && peripheral_irq_enable_r;
      awready_nxt = !aw_full_nxt && !bvalid_nxt;
      wready_nxt = !w_full_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_r <= '0;
         rate_r <= ast_pkg::RATE_RESET;
         buf_r <= 8'h00;
         buf_ninth_r <= 1'b0;
         buf_full_r <= 1'b0;
         shift_r <= 10'h3FF;
         bits_left_r <= 4'h0;
         ovs_r <= 6'h00;
         state_r <= ast_pkg::TX_IDLE;
         flag_dly_r <= '0;
         empty_dly_r <= '1;
         tx_flag_r <= 1'b0;
         shift_empty_r <= ast_pkg::CTRL_RESET[ast_pkg::BIT_SHIFT_EMPTY];
         tx_irq_en_r <= 1'b0;
         gie_r <= 1'b0;
         peripheral_irq_enable_r <= 1'b0;
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
         serial_out_pin_o <= 1'b1;
         serial_out_pin_oe <= 1'b0;
         tx_irq <= 1'b0;
         cpu_irq <= 1'b0;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         rate_r <= rate_nxt;
         buf_r <= buf_nxt;
         buf_ninth_r <= buf_ninth_nxt;
         buf_full_r <= buf_full_nxt;
         shift_r <= shift_nxt;
         bits_left_r <= bits_left_nxt;
         ovs_r <= ovs_nxt;
         state_r <= state_nxt;
         flag_dly_r <= flag_dly_nxt;
         empty_dly_r <= empty_dly_nxt;
         tx_flag_r <= tx_flag_nxt;
         shift_empty_r <= shift_empty_nxt;
         tx_irq_en_r <= tx_irq_en_nxt;
         gie_r <= gie_nxt;
         peripheral_irq_enable_r <= peripheral_irq_enable_nxt;
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         s_axi_awready <= awready_nxt;
         s_axi_wready <= wready_nxt;
         s_axi_bvalid <= bvalid_nxt;
         s_axi_bresp <= bresp_nxt;
         s_axi_arready <= arready_nxt;
         s_axi_rvalid <= rvalid_nxt;
         s_axi_rresp <= rresp_nxt;
         s_axi_rdata <= rdata_nxt;
         serial_out_pin_o <= line_nxt;
         serial_out_pin_oe <= oe_nxt;
         tx_irq <= tx_irq_nxt;
         cpu_irq <= cpu_irq_nxt;
      end
   end
endmodule
